// ### pkg/fpec_pkg.sv
// flash sequencer constants
//
// Function
// - nothing runs unless the unlock directly precedes start.
// - control bit 15 starts the operation; hardware clears it.
// - start is set by software only; zero means idle.
// - core stays stalled for the whole operation.
// - write enable, bit 14, must be one to operate.
// - bit 13 flags bad attempts and aborts; completion clears it.
// - erase select, bit 6, picks erase or program.
// - 0011 word, 0001 row program, 0010 page erase; mismatch starts nothing and sets bit 13.
// - 1111 with erase is bulk erase, serial programming mode only.
// - other codes start nothing.
// - control bits other than start and bit 13 clear on power-on reset only; start also clears on soft reset.
// - bits 12 to 7 and 5 to 4 read zero.
// - table writes sit in holding latches until a sequence runs.
// - address is table page upper byte plus 16-bit address.
package fpec_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h04;
    localparam logic [7:0] ADDR_TABLE_PAGE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int BIT_START = 15;
    localparam int BIT_WRITE_ENABLE = 14;
    localparam int BIT_SEQ_ERROR = 13;
    localparam int BIT_ERASE_SELECT = 6;
    localparam int OP_SELECT_MSB = 3;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [7:0] TABLE_PAGE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // key values and operation codes
    // ----------------------------------------------------------------
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [3:0] OP_ROW_PROGRAM = 4'h1;
    localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
    localparam logic [3:0] OP_WORD_PROGRAM = 4'h3;
    localparam logic [3:0] OP_BULK_ERASE = 4'hF;

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int ROW_WORDS = 64;
    localparam logic [23:0] ROW_BASE_MASK = 24'hFFFF80;
    localparam logic [23:0] BLOCK_BASE_MASK = 24'hFFFC00;

    // ----------------------------------------------------------------
    // self-timed operation durations
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WORD_PROGRAM_NS = 20000;
    localparam int T_ROW_PROGRAM_NS = 40000;
    localparam int T_PAGE_ERASE_NS = 200000;
    localparam int T_BULK_ERASE_NS = 400000;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FPEC_IDLE = 2'b00,
        FPEC_STREAM = 2'b01,
        FPEC_WAIT = 2'b10
    } fpec_state_t;

    typedef enum logic [1:0] {
        FPEC_KEY_NONE = 2'b00,
        FPEC_KEY_HALF = 2'b01,
        FPEC_KEY_OPEN = 2'b10
    } fpec_key_t;

endpackage : fpec_pkg

// ### rtl/fpec_latch_mem.sv
// holding latch memory for one row of program words
`timescale 1ns/1ps
`default_nettype none
module fpec_latch_mem #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // clock
    input wire logic clk_sys,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read side
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    // latches carry no reset
    logic [WIDTH-1:0] mem [DEPTH];

    // ----------------------------------------------------------------
    // write and registered read
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : fpec_latch_mem
`default_nettype wire

// ### rtl/fpec_top.sv
// flash program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
module fpec_top #(
    parameter int WORD_PROGRAM_CYCLES = fpec_pkg::T_WORD_PROGRAM_NS / fpec_pkg::CLK_PERIOD_NS,
    parameter int ROW_PROGRAM_CYCLES = fpec_pkg::T_ROW_PROGRAM_NS / fpec_pkg::CLK_PERIOD_NS,
    parameter int PAGE_ERASE_CYCLES = fpec_pkg::T_PAGE_ERASE_NS / fpec_pkg::CLK_PERIOD_NS,
    parameter int BULK_ERASE_CYCLES = fpec_pkg::T_BULK_ERASE_NS / fpec_pkg::CLK_PERIOD_NS
) (
    // clock and power-on reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // other reset sources, same clock
    input wire logic soft_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // table write port from the core
    input wire logic table_write_instr,
    input wire logic [15:0] table_ea,
    input wire logic [23:0] table_data,
    // serial programming mode pin
    input wire logic serial_programming_mode,
    // core stall
    output logic cpu_stall,
    // flash array side
    output logic flash_word_we,
    output logic flash_page_erase,
    output logic flash_bulk_erase,
    output logic [23:0] flash_addr,
    output logic [23:0] flash_wdata,
    output logic flash_busy
);

    localparam int CW = 20;
    localparam logic [CW-1:0] CNT_WORD = CW'(WORD_PROGRAM_CYCLES);
    localparam logic [CW-1:0] CNT_ROW = CW'(ROW_PROGRAM_CYCLES);
    localparam logic [CW-1:0] CNT_PAGE = CW'(PAGE_ERASE_CYCLES);
    localparam logic [CW-1:0] CNT_BULK = CW'(BULK_ERASE_CYCLES);
    localparam logic [5:0] LAST_IDX = 6'(fpec_pkg::ROW_WORDS - 1);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic start_bit;
    logic write_enable;
    logic seq_error;
    logic erase_select;
    logic [3:0] op_select;
    logic [7:0] table_page;
    logic [23:0] target_addr;
    fpec_pkg::fpec_key_t key_stage;
    fpec_pkg::fpec_state_t state;
    logic serial_meta;
    logic serial_sync;
    logic [CW-1:0] timer;
    logic [5:0] stream_idx;
    logic [5:0] stream_idx_d;
    logic stream_rd_v;
    logic stream_last;
    logic is_row;
    logic is_erase_op;
    logic [5:0] mem_rd_addr;
    logic [23:0] mem_rd_data;
    logic ctrl_wr;
    logic start_req;
    logic op_valid;
    logic launch;
    logic refuse;
    logic busy;
    logic done;
    logic [15:0] ctrl_view;
    logic [15:0] next_rdata;

    // ----------------------------------------------------------------
    // bus decode and start request qualification
    // ----------------------------------------------------------------
    assign busy = (state != fpec_pkg::FPEC_IDLE);
    assign ctrl_wr = reg_wr && (reg_addr == fpec_pkg::ADDR_CONTROL);
    assign start_req = ctrl_wr && reg_wdata[fpec_pkg::BIT_START] && !busy;

    // decode of the code the start write carries
    always_comb
    begin
        op_valid = 1'b0;
        unique case (reg_wdata[fpec_pkg::OP_SELECT_MSB:0])
            fpec_pkg::OP_ROW_PROGRAM: op_valid = !reg_wdata[fpec_pkg::BIT_ERASE_SELECT];
            fpec_pkg::OP_WORD_PROGRAM: op_valid = !reg_wdata[fpec_pkg::BIT_ERASE_SELECT];
            fpec_pkg::OP_PAGE_ERASE: op_valid = reg_wdata[fpec_pkg::BIT_ERASE_SELECT];
            fpec_pkg::OP_BULK_ERASE: op_valid = reg_wdata[fpec_pkg::BIT_ERASE_SELECT]
                && serial_sync;
            default: op_valid = 1'b0;
        endcase
    end

    // launch needs key, enable and valid code
    assign launch = start_req && (key_stage == fpec_pkg::FPEC_KEY_OPEN)
        && reg_wdata[fpec_pkg::BIT_WRITE_ENABLE] && op_valid;
    assign refuse = start_req && !launch;

    // ----------------------------------------------------------------
    // serial programming mode pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            serial_meta <= 1'b0;
            serial_sync <= 1'b0;
        end
        else
        begin
            serial_meta <= serial_programming_mode;
            serial_sync <= serial_meta;
        end
    end

    // ----------------------------------------------------------------
    // unlock key tracker
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            key_stage <= fpec_pkg::FPEC_KEY_NONE;
        end
        else if (reg_wr && reg_addr == fpec_pkg::ADDR_UNLOCK_KEY
            && reg_wdata[7:0] == fpec_pkg::KEY_FIRST)
        begin
            key_stage <= fpec_pkg::FPEC_KEY_HALF;
        end
        else if (reg_wr && reg_addr == fpec_pkg::ADDR_UNLOCK_KEY
            && reg_wdata[7:0] == fpec_pkg::KEY_SECOND
            && key_stage == fpec_pkg::FPEC_KEY_HALF)
        begin
            key_stage <= fpec_pkg::FPEC_KEY_OPEN;
        end
        else if (reg_wr || reg_rd || table_write_instr || soft_rst)
        begin
            key_stage <= fpec_pkg::FPEC_KEY_NONE;
        end
    end

    // ----------------------------------------------------------------
    // control bits; write enable, erase select and code cleared by power-on reset only
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            write_enable <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_WRITE_ENABLE];
            erase_select <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_ERASE_SELECT];
            op_select <= fpec_pkg::CONTROL_RESET[fpec_pkg::OP_SELECT_MSB:0];
        end
        else if (ctrl_wr && !busy)
        begin
            write_enable <= reg_wdata[fpec_pkg::BIT_WRITE_ENABLE];
            erase_select <= reg_wdata[fpec_pkg::BIT_ERASE_SELECT];
            op_select <= reg_wdata[fpec_pkg::OP_SELECT_MSB:0];
        end
    end

    // start bit: set by software only, cleared by hardware when done
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            start_bit <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_START];
        end
        else if (launch)
        begin
            start_bit <= 1'b1;
        end
        else if (done || soft_rst)
        begin
            start_bit <= 1'b0;
        end
    end

    // error flag: bad attempt or abort sets, completion clears
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            seq_error <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_SEQ_ERROR];
        end
        else if (refuse || (soft_rst && busy))
        begin
            seq_error <= 1'b1;
        end
        else if (done)
        begin
            seq_error <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // table page and latched target address
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            table_page <= fpec_pkg::TABLE_PAGE_RESET;
            target_addr <= 24'h000000;
        end
        else
        begin
            if (reg_wr && reg_addr == fpec_pkg::ADDR_TABLE_PAGE)
            begin
                table_page <= reg_wdata[7:0];
            end
            if (table_write_instr && !busy)
            begin
                target_addr <= {table_page, table_ea};
            end
        end
    end

    // ----------------------------------------------------------------
    // holding latches
    // ----------------------------------------------------------------
    assign mem_rd_addr = (state == fpec_pkg::FPEC_STREAM) ? stream_idx : target_addr[6:1];

    fpec_latch_mem #(
        .WIDTH(24),
        .DEPTH(fpec_pkg::ROW_WORDS),
        .AW(6)
    ) u_latch (
        .clk_sys(clk_sys),
        .wr_en(table_write_instr && !busy),
        .wr_addr(table_ea[6:1]),
        .wr_data(table_data),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    // ----------------------------------------------------------------
    // operation sequencer
    // ----------------------------------------------------------------
    assign is_row = (op_select == fpec_pkg::OP_ROW_PROGRAM);
    assign is_erase_op = erase_select;
    assign stream_last = is_row ? (stream_idx == LAST_IDX) : 1'b1;
    assign done = (state == fpec_pkg::FPEC_WAIT) && (timer == '0) && !soft_rst;

    // state and timer
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || soft_rst)
        begin
            state <= fpec_pkg::FPEC_IDLE;
            timer <= '0;
            stream_idx <= 6'h00;
        end
        else
        begin
            unique case (state)
                fpec_pkg::FPEC_IDLE:
                begin
                    if (launch)
                    begin
                        stream_idx <= is_row_code(reg_wdata[3:0]) ? 6'h00
                            : target_addr[6:1];
                        if (reg_wdata[fpec_pkg::BIT_ERASE_SELECT])
                        begin
                            state <= fpec_pkg::FPEC_WAIT;
                            timer <= (reg_wdata[3:0] == fpec_pkg::OP_BULK_ERASE)
                                ? CNT_BULK : CNT_PAGE;
                        end
                        else
                        begin
                            state <= fpec_pkg::FPEC_STREAM;
                        end
                    end
                end
                fpec_pkg::FPEC_STREAM:
                begin
                    if (stream_last)
                    begin
                        state <= fpec_pkg::FPEC_WAIT;
                        timer <= is_row ? CNT_ROW : CNT_WORD;
                    end
                    else
                    begin
                        stream_idx <= stream_idx + 6'h01;
                    end
                end
                fpec_pkg::FPEC_WAIT:
                begin
                    if (timer == '0)
                    begin
                        state <= fpec_pkg::FPEC_IDLE;
                    end
                    else
                    begin
                        timer <= timer - CW'(1);
                    end
                end
                default:
                begin
                    state <= fpec_pkg::FPEC_IDLE;
                end
            endcase
        end
    end

    // row code test on the start write data
    function automatic logic is_row_code(input logic [3:0] code);
        is_row_code = (code == fpec_pkg::OP_ROW_PROGRAM);
    endfunction : is_row_code

    // read pipeline tracking for latch data
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || soft_rst)
        begin
            stream_rd_v <= 1'b0;
            stream_idx_d <= 6'h00;
        end
        else
        begin
            stream_rd_v <= (state == fpec_pkg::FPEC_STREAM);
            stream_idx_d <= stream_idx;
        end
    end

    // ----------------------------------------------------------------
    // flash array drive
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            flash_word_we <= 1'b0;
            flash_page_erase <= 1'b0;
            flash_bulk_erase <= 1'b0;
            flash_addr <= 24'h000000;
            flash_wdata <= 24'h000000;
        end
        else
        begin
            flash_word_we <= stream_rd_v && !soft_rst;
            flash_page_erase <= launch && (reg_wdata[3:0] == fpec_pkg::OP_PAGE_ERASE);
            flash_bulk_erase <= launch && (reg_wdata[3:0] == fpec_pkg::OP_BULK_ERASE);
            if (stream_rd_v)
            begin
                flash_addr <= (target_addr & fpec_pkg::ROW_BASE_MASK) | {17'h00000,
                    stream_idx_d, 1'b0};
                flash_wdata <= mem_rd_data;
            end
            else if (launch)
            begin
                flash_addr <= target_addr & fpec_pkg::BLOCK_BASE_MASK;
            end
        end
    end

    // stall and busy for the whole operation
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cpu_stall <= 1'b0;
            flash_busy <= 1'b0;
        end
        else
        begin
            cpu_stall <= (launch || (busy && !done)) && !soft_rst;
            flash_busy <= (launch || (busy && !done)) && !soft_rst;
        end
    end

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    always_comb
    begin
        ctrl_view = 16'h0000;
        ctrl_view[fpec_pkg::BIT_START] = start_bit;
        ctrl_view[fpec_pkg::BIT_WRITE_ENABLE] = write_enable;
        ctrl_view[fpec_pkg::BIT_SEQ_ERROR] = seq_error;
        ctrl_view[fpec_pkg::BIT_ERASE_SELECT] = is_erase_op;
        ctrl_view[fpec_pkg::OP_SELECT_MSB:0] = op_select;
        next_rdata = 16'h0000;
        unique case (reg_addr)
            fpec_pkg::ADDR_CONTROL: next_rdata = ctrl_view;
            fpec_pkg::ADDR_TABLE_PAGE: next_rdata = {8'h00, table_page};
            fpec_pkg::ADDR_STATUS: next_rdata = {12'h000, serial_sync, busy,
                key_stage == fpec_pkg::FPEC_KEY_OPEN, key_stage == fpec_pkg::FPEC_KEY_HALF};
            default: next_rdata = 16'h0000;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_rd)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule : fpec_top
`default_nettype wire

// ### rtl/fpec_fix_note.sv
// no logic: reserved file

// ### tb/fpec_top_monitor.sv
// assertions for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fpec_top_monitor #(
    parameter int WORD_PROGRAM_CYCLES = 4,
    parameter int ROW_PROGRAM_CYCLES = 8,
    parameter int PAGE_ERASE_CYCLES = 10,
    parameter int BULK_ERASE_CYCLES = 12
) (
    // clock and resets
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic soft_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // core and array side
    input wire logic serial_programming_mode,
    input wire logic cpu_stall,
    input wire logic flash_word_we,
    input wire logic flash_page_erase,
    input wire logic flash_bulk_erase,
    input wire logic flash_busy
);
    localparam int MAX_STALL = 82 + ROW_PROGRAM_CYCLES + PAGE_ERASE_CYCLES
        + BULK_ERASE_CYCLES + WORD_PROGRAM_CYCLES;
    int stall_cnt;
    logic ok_op;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // legal start write
    assign ok_op = reg_wdata[15:14] == 2'b11 && ((reg_wdata[3:0] == 4'h1 ||
        reg_wdata[3:0] == 4'h3) ? !reg_wdata[6] : reg_wdata[3:0] == 4'h2 && reg_wdata[6]);
    // stall length
    always_ff @(posedge clk_sys)
    begin
        stall_cnt <= cpu_stall ? stall_cnt + 1 : 0;
    end
    sequence s_keys;
        reg_wr && reg_addr == fpec_pkg::ADDR_UNLOCK_KEY && reg_wdata[7:0] == 8'h55
        ##1 reg_wr && reg_addr == fpec_pkg::ADDR_UNLOCK_KEY && reg_wdata[7:0] == 8'hAA;
    endsequence
    sequence s_start;
        reg_wr && reg_addr == fpec_pkg::ADDR_CONTROL && ok_op;
    endsequence
    a_launch_after_keys: assert property (!cpu_stall ##0 s_keys ##1 s_start |=> cpu_stall)
        else $error("start not launched");
    a_stall_needs_keys: assert property ($rose(cpu_stall) |-> $past(reg_wr, 1)
        && $past(reg_wdata[7:0], 2) == 8'hAA && $past(reg_wdata[7:0], 3) == 8'h55)
        else $error("launch without keys");
    a_stall_busy_match: assert property (cpu_stall == flash_busy)
        else $error("busy and stall disagree");
    a_stall_bounded: assert property (stall_cnt <= MAX_STALL)
        else $error("stall too long");
    a_one_erase_pulse: assert property (flash_page_erase |=> !flash_page_erase)
        else $error("long erase pulse");
    a_erase_exclusive: assert property (!(flash_page_erase && flash_bulk_erase))
        else $error("page and bulk erase together");
    a_bulk_needs_serial: assert property (flash_bulk_erase |-> serial_programming_mode)
        else $error("bulk erase not serial");
    a_word_we_stalled: assert property (flash_word_we |-> cpu_stall)
        else $error("array write while idle");
    a_ctrl_unimpl_zero: assert property ($past(reg_rd && reg_addr == 8'h00)
        |-> reg_rdata[12:7] == 6'h00 && reg_rdata[5:4] == 2'h0)
        else $error("unused bits nonzero");
    a_soft_abort: assert property (soft_rst |=> !cpu_stall)
        else $error("abort failed");
endmodule : fpec_top_monitor
bind fpec_top fpec_top_monitor #(.WORD_PROGRAM_CYCLES(WORD_PROGRAM_CYCLES),
    .ROW_PROGRAM_CYCLES(ROW_PROGRAM_CYCLES), .PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES),
    .BULK_ERASE_CYCLES(BULK_ERASE_CYCLES)) mon_u (.clk_sys, .rst_b, .soft_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_programming_mode, .cpu_stall,
    .flash_word_we, .flash_page_erase, .flash_bulk_erase, .flash_busy);
`default_nettype wire

// ### tb/fpec_core_model.sv
// processor core model: register accesses and table writes
`timescale 1ns/1ps
`default_nettype none
module fpec_core_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // table write port
    output logic table_write_instr,
    output logic [15:0] table_ea,
    output logic [23:0] table_data
);
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {table_write_instr, table_ea, table_data} = '0;
    end
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : wr
    // release; data flips
    task idle;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        table_write_instr <= 1'b0;
        reg_wdata <= ~reg_wdata;
    endtask : idle
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask : rd
    // latch load
    task tbl(input logic [15:0] ea, input logic [23:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        table_write_instr <= 1'b1;
        table_ea <= ea;
        table_data <= d;
        idle();
    endtask : tbl
    // keys, start, two quiet cycles
    task unlock_start(input logic [15:0] ctl);
        wr(fpec_pkg::ADDR_UNLOCK_KEY, 16'h0055);
        wr(fpec_pkg::ADDR_UNLOCK_KEY, 16'h00AA);
        wr(fpec_pkg::ADDR_CONTROL, ctl | 16'h8000);
        repeat (2) idle();
    endtask : unlock_start
endmodule : fpec_core_model
`default_nettype wire

// ### tb/test_flash_program_erase_control.sv
// bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_erase_control;
    logic clk_sys = 0, rst_b = 0, soft_rst = 0, serial_programming_mode = 0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, table_ea;
    logic reg_wr, reg_rd, table_write_instr, cpu_stall, flash_busy;
    logic flash_word_we, flash_page_erase, flash_bulk_erase;
    logic [23:0] table_data, flash_addr, flash_wdata, last_addr, last_data;
    int num_errors = 0, tests_run = 0, n_we, n_pe, n_be;
    always #5 clk_sys = ~clk_sys;
    fpec_top #(.WORD_PROGRAM_CYCLES(4), .ROW_PROGRAM_CYCLES(8), .PAGE_ERASE_CYCLES(10),
        .BULK_ERASE_CYCLES(12)) dut_u (.clk_sys, .rst_b, .soft_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .table_write_instr, .table_ea, .table_data,
        .serial_programming_mode, .cpu_stall, .flash_word_we, .flash_page_erase,
        .flash_bulk_erase, .flash_addr, .flash_wdata, .flash_busy);
    fpec_core_model core_u (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .table_write_instr, .table_ea, .table_data);
    // count array events
    always @(posedge clk_sys)
    begin
        n_we += flash_word_we;
        n_pe += flash_page_erase;
        n_be += flash_bulk_erase;
        if (flash_word_we || flash_page_erase || flash_bulk_erase)
        begin
            last_addr = flash_addr;
            last_data = flash_wdata;
        end
    end
    task chk(input string n, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task summarize;
        $display("mismatches %0d comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // bounded wait for idle
    task wait_idle(output logic st);
        int i;
        for (i = 0; i < 300; i++)
        begin
            @(posedge clk_sys);
            if (i == 0)
                st = cpu_stall;
            if (cpu_stall !== 1'b1)
                break;
        end
        if (i == 300)
        begin
            num_errors++;
            $display("BAD stall timeout");
            summarize();
        end
    endtask : wait_idle
    initial
    begin
        logic [15:0] rdv, ea, ctl;
        logic [7:0] pg;
        logic [23:0] dat;
        logic st, ok, e, ser;
        logic [3:0] op;
        int k;
        k = $urandom(54602);
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        core_u.rd(fpec_pkg::ADDR_CONTROL, rdv);
        chk("ctrl reset", 24'h0, rdv);
        core_u.wr(fpec_pkg::ADDR_CONTROL, 16'h7FFF);
        core_u.rd(fpec_pkg::ADDR_CONTROL, rdv);
        chk("ctrl mask", 24'h404F, rdv);
        for (k = 0; k < 32; k++)
        begin
            op = k[3:0];
            e = k[4];
            ser = 1'($urandom);
            serial_programming_mode <= ser;
            pg = 8'($urandom);
            ea = 16'($urandom) & 16'hFFFE;
            dat = 24'($urandom);
            core_u.wr(fpec_pkg::ADDR_TABLE_PAGE, {8'h00, pg});
            core_u.tbl(ea, dat);
            {n_we, n_pe, n_be} = '0;
            ctl = {2'b01, 7'h00, e, 2'b00, op};
            core_u.unlock_start(ctl);
            ok = ((op == 4'h1 || op == 4'h3) && !e) || (op == 4'h2 && e) || (op == 4'hF && e && ser);
            wait_idle(st);
            chk("stall", ok, st);
            chk("words", !ok ? 0 : op == 4'h1 ? 64 : op == 4'h3 ? 1 : 0, n_we);
            chk("page erase", ok && op == 4'h2, n_pe);
            chk("bulk erase", ok && op == 4'hF, n_be);
            if (ok && op == 4'h3)
            begin
                chk("word addr", {pg, ea}, last_addr);
                chk("word data", dat, last_data);
            end
            if (ok && op == 4'h2)
                chk("block addr", {pg, ea} & fpec_pkg::BLOCK_BASE_MASK, last_addr);
            core_u.rd(fpec_pkg::ADDR_CONTROL, rdv);
            chk("ctrl after", {8'h00, ctl | (16'(!ok) << 13)}, rdv);
        end
        for (k = 0; k < 3; k++)
        begin
            core_u.wr(fpec_pkg::ADDR_UNLOCK_KEY, k == 1 ? 16'h00AA : 16'h0055);
            if (k == 0)
                core_u.rd(fpec_pkg::ADDR_CONTROL, rdv);
            core_u.wr(fpec_pkg::ADDR_UNLOCK_KEY, k == 1 ? 16'h0055 : 16'h00AA);
            core_u.wr(fpec_pkg::ADDR_CONTROL, k == 2 ? 16'h8001 : 16'hC001);
            core_u.idle();
            wait_idle(st);
            chk("refused stall", 1'b0, st);
            core_u.rd(fpec_pkg::ADDR_CONTROL, rdv);
            chk("refused ctrl", k == 2 ? 24'h2001 : 24'h6001, rdv);
        end
        core_u.unlock_start(16'h4042);
        repeat (3) @(posedge clk_sys);
        soft_rst <= 1'b1;
        @(posedge clk_sys);
        soft_rst <= 1'b0;
        wait_idle(st);
        core_u.rd(fpec_pkg::ADDR_CONTROL, rdv);
        chk("abort ctrl", 24'h6042, rdv);
        summarize();
    end
endmodule : test_flash_program_erase_control
`default_nettype wire
